// file: hdl/dse_pkg.sv
// Package: command codes, register fields, control word layout, structs
package dse_pkg;
    // Command codes
    localparam logic [7:0] CMD_SET_PW      = 8'hF1;
    localparam logic [7:0] CMD_UNLOCK      = 8'hF2;
    localparam logic [7:0] CMD_PREPARE     = 8'hF3;
    localparam logic [7:0] CMD_ERASE       = 8'hF4;
    localparam logic [7:0] CMD_FREEZE      = 8'hF5;
    localparam logic [7:0] CMD_DISABLE_PW  = 8'hF6;
    // Status register bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    // Error register bit positions
    localparam int ER_ABT = 2;
    // Control word fields
    localparam int CW_MASTER = 0;
    localparam int CW_ENH    = 1;
    // Sector layout: password words and sector size
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD  = 16;
    localparam int SECTOR_WORDS  = 256;
    localparam int PW_WORDS      = 16;
    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] ERROR_RST  = 8'h00;
    localparam logic [63:0] LBA_FIRST = 64'h0;
    // Identify words reporting erase time
    localparam logic [7:0] ID_WORD_NORMAL   = 8'h59;
    localparam logic [7:0] ID_WORD_ENHANCED = 8'h5A;

    // Command issue from the task file
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } dse_cmd_t;

    // Erase request toward the media engine
    typedef struct packed {
        logic        start;
        logic        enhanced;
        logic [47:0] last_lba;
    } dse_erase_t;
endpackage : dse_pkg

// file: hdl/dse_core.sv
// Security erase and freeze command handling for the task-file interface
// What this block does
// - Command code F4h starts an erase of the whole medium, password-checked while lock is enabled.
// - Erase runs from block zero to native maximum, ignoring host maximum.
// - After accepting erase, request exactly one sector of host data.
// - Password mismatch aborts the erase with an aborted-command error.
// - Control word bit 0 selects master (1) or user (0) password.
// - Control word bit 1 selects enhanced (1) or normal (0) erase.
// - Words 1-16 hold the password; other words and bits are ignored.
// - Erase writes zeros, no verify, defect lists left untouched.
// - Erase not directly preceded by a completed prepare is aborted.
// - Completed erase disables the lock function, master password kept.
// - With lock disabled, password comparison is skipped and erase runs.
// - Identify words 89 and 90 report normal and enhanced erase times.
// - Command code F5h enters frozen state at once, no data transfer.
// - While frozen, lock-changing commands are rejected.
// - Frozen state clears only at power-up, not by any reset.
// - Prepare has no data phase; it only arms the following erase.
`timescale 1ns/100ps
`default_nettype none
module dse_core #(
    parameter logic [15:0] NORMAL_TIME   = 16'h0001,
    parameter logic [15:0] ENHANCED_TIME = 16'h0001
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Command issue
    input  wire dse_pkg::dse_cmd_t cmd_i,
    // Sector data in, one word per strobe
    input  wire logic              wr_strobe_i,
    input  wire logic [15:0]       wr_data_i,
    // Stored security state
    input  wire logic [255:0]      master_pw_i,
    input  wire logic [255:0]      user_pw_i,
    input  wire logic              lock_en_i,
    input  wire logic [47:0]       native_max_i,
    // Erase engine handshake
    output dse_pkg::dse_erase_t    erase_o,
    input  wire logic              erase_done_i,
    // Lock function disable request
    output logic                   lock_clear_o,
    // Identify word lookup
    input  wire logic [7:0]        id_word_i,
    output logic [15:0]            id_data_o,
    // Task-file registers and state
    output logic [7:0]             command_status_flags_o,
    output logic [7:0]             command_error_flags_o,
    output logic                   frozen_o
);

    typedef enum logic [1:0] {
        DSE_IDLE,
        DSE_XFER,
        DSE_ERASE
    } dse_state_t;

    dse_state_t     state_q;
    logic [7:0]     wcnt_q;
    logic [15:0]    ctrl_q;
    logic [255:0]   pw_q;
    logic           armed_q;
    logic           frozen_q = 1'b0; // Power-up value only
    logic [7:0]     status_q;
    logic [7:0]     error_q;
    dse_pkg::dse_erase_t erase_q;
    logic           lock_clear_q;
    logic           last_word;
    logic           pw_ok;
    logic           is_lockcmd;

    assign last_word  = wcnt_q == 8'(dse_pkg::SECTOR_WORDS - 1);
    // Compare against the password the control word names
    assign pw_ok = ctrl_q[dse_pkg::CW_MASTER] ? (pw_q == master_pw_i)
                                              : (pw_q == user_pw_i);
    assign is_lockcmd = cmd_i.code == dse_pkg::CMD_SET_PW  ||
                        cmd_i.code == dse_pkg::CMD_UNLOCK  ||
                        cmd_i.code == dse_pkg::CMD_DISABLE_PW ||
                        cmd_i.code == dse_pkg::CMD_ERASE;

    // Frozen flag: set by freeze, only the power-up value clears it
    always_ff @(posedge clk_i) begin
        if (cmd_i.valid && state_q == DSE_IDLE &&
            cmd_i.code == dse_pkg::CMD_FREEZE) begin
            frozen_q <= 1'b1;
        end
    end

    // Prepare arming: any other command disarms
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
        end else if (cmd_i.valid && state_q == DSE_IDLE) begin
            armed_q <= cmd_i.code == dse_pkg::CMD_PREPARE;
        end
    end

    // Command sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= DSE_IDLE;
        end else begin
            case (state_q)
                DSE_IDLE: begin
                    if (cmd_i.valid && cmd_i.code == dse_pkg::CMD_ERASE &&
                        !frozen_q && armed_q) begin
                        state_q <= DSE_XFER;
                    end
                end
                DSE_XFER: begin
                    if (wr_strobe_i && last_word) begin
                        state_q <= DSE_ERASE;
                    end
                end
                DSE_ERASE: begin
                    if (erase_q.start) begin
                        if (lock_en_i && !pw_ok) begin
                            state_q <= DSE_IDLE;
                        end
                    end else if (erase_done_i) begin
                        state_q <= DSE_IDLE;
                    end
                end
                default: state_q <= DSE_IDLE;
            endcase
        end
    end

    // Word counter for the one data sector
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_q == DSE_IDLE) begin
            wcnt_q <= 8'h00;
        end else if (state_q == DSE_XFER && wr_strobe_i) begin
            wcnt_q <= wcnt_q + 8'h01;
        end
    end

    // Capture control word and password; reserved words dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= 16'h0000;
            pw_q   <= '0;
        end else if (state_q == DSE_XFER && wr_strobe_i) begin
            if (wcnt_q == 8'h00) begin
                ctrl_q <= wr_data_i;
            end else if (wcnt_q <= 8'(dse_pkg::PW_LAST_WORD)) begin
                pw_q <= {pw_q[239:0], wr_data_i};
            end
        end
    end

    // Erase request: one pulse over the native range after the sector
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            erase_q <= '0;
        end else begin
            erase_q.start <= 1'b0;
            if (state_q == DSE_XFER && wr_strobe_i && last_word) begin
                erase_q.start <= 1'b1;
            end
            if (erase_q.start && lock_en_i && !pw_ok) begin
                erase_q.start <= 1'b0;
            end
            erase_q.enhanced <= ctrl_q[dse_pkg::CW_ENH];
            erase_q.last_lba <= native_max_i;
        end
    end
    // Engine writes zeros from block zero, no verify, defects untouched
    assign erase_o.start    = erase_q.start && (!lock_en_i || pw_ok);
    assign erase_o.enhanced = erase_q.enhanced;
    assign erase_o.last_lba = erase_q.last_lba;

    // Lock disable pulse on completion; master password untouched
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lock_clear_q <= 1'b0;
        end else begin
            lock_clear_q <= state_q == DSE_ERASE && !erase_q.start &&
                            erase_done_i;
        end
    end
    assign lock_clear_o = lock_clear_q;

    // Status and error registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            status_q <= dse_pkg::STATUS_RST;
            error_q  <= dse_pkg::ERROR_RST;
        end else if (state_q == DSE_IDLE && cmd_i.valid) begin
            status_q <= dse_pkg::STATUS_RST;
            error_q  <= dse_pkg::ERROR_RST;
            if ((frozen_q && is_lockcmd) ||
                (cmd_i.code == dse_pkg::CMD_ERASE && !armed_q)) begin
                status_q[dse_pkg::ST_ERR] <= 1'b1;
                error_q[dse_pkg::ER_ABT]  <= 1'b1;
            end else if (cmd_i.code == dse_pkg::CMD_ERASE) begin
                status_q[dse_pkg::ST_BSY] <= 1'b0;
                status_q[dse_pkg::ST_DRQ] <= 1'b1;
            end
        end else if (state_q == DSE_XFER && wr_strobe_i && last_word) begin
            status_q[dse_pkg::ST_DRQ] <= 1'b0;
            status_q[dse_pkg::ST_BSY] <= 1'b1;
        end else if (state_q == DSE_ERASE && erase_q.start &&
                     lock_en_i && !pw_ok) begin
            status_q <= dse_pkg::STATUS_RST | 8'h01;
            error_q[dse_pkg::ER_ABT] <= 1'b1;
        end else if (state_q == DSE_ERASE && !erase_q.start && erase_done_i) begin
            status_q <= dse_pkg::STATUS_RST;
        end
    end

    // Identify words for erase durations
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            id_data_o <= 16'h0000;
        end else begin
            case (id_word_i)
                dse_pkg::ID_WORD_NORMAL:   id_data_o <= NORMAL_TIME;
                dse_pkg::ID_WORD_ENHANCED: id_data_o <= ENHANCED_TIME;
                default:                   id_data_o <= 16'h0000;
            endcase
        end
    end

    assign command_status_flags_o = status_q;
    assign command_error_flags_o  = error_q;
    assign frozen_o               = frozen_q;

    // Checks
    sequence s_sector_end;
        state_q == DSE_XFER && wr_strobe_i && last_word;
    endsequence

    AST_UNARMED_ABORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == DSE_IDLE && cmd_i.valid && cmd_i.code == dse_pkg::CMD_ERASE
        && !armed_q |=> command_error_flags_o[dse_pkg::ER_ABT]
        && state_q == DSE_IDLE)
        else $error("erase without prepare not aborted");
    AST_FREEZE_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == DSE_IDLE && cmd_i.valid && cmd_i.code == dse_pkg::CMD_FREEZE
        |=> frozen_o)
        else $error("freeze not entered");
    AST_FROZEN_STAYS: assert property (@(posedge clk_i)
        $past(frozen_o) |-> frozen_o)
        else $error("frozen state cleared");
    AST_FROZEN_REJECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        frozen_o && state_q == DSE_IDLE && cmd_i.valid && is_lockcmd
        |=> command_status_flags_o[dse_pkg::ST_ERR] && state_q == DSE_IDLE)
        else $error("lock command accepted while frozen");
    AST_ONE_SECTOR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_sector_end |=> state_q == DSE_ERASE
        && !command_status_flags_o[dse_pkg::ST_DRQ])
        else $error("data request after one sector");
    AST_BAD_PW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        erase_q.start && lock_en_i && !pw_ok |-> !erase_o.start
        ##1 command_error_flags_o[dse_pkg::ER_ABT])
        else $error("mismatch not aborted");
    AST_UNLOCKED_ERASE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        erase_q.start && !lock_en_i |-> erase_o.start)
        else $error("erase skipped while unlocked");
    AST_LOCK_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == DSE_ERASE && !erase_q.start && erase_done_i
        |=> lock_clear_o && state_q == DSE_IDLE)
        else $error("lock not cleared after erase");
    AST_NATIVE_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        erase_o.start |-> erase_o.last_lba == $past(native_max_i))
        else $error("erase range not native maximum");

endmodule : dse_core
`default_nettype wire

// file: sim/dse_engine_model.sv
// Erase engine model: zero-fills after a set delay, then reports done
`timescale 1ns/100ps
`default_nettype none
module dse_engine_model (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Erase request, delay and completion
    input  wire dse_pkg::dse_erase_t erase_i,
    input  wire logic [7:0]          delay_i,
    output logic                     done_o,
    // Last request seen and count of requests
    output logic                     enh_o,
    output logic [47:0]              lba_o,
    output int                       starts_o
);
    int cnt_q;
    // Capture request, count down, pulse done
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            cnt_q    <= 0;
            starts_o <= 0;
        end else if (erase_i.start) begin
            enh_o    <= erase_i.enhanced;
            lba_o    <= erase_i.last_lba;
            starts_o <= starts_o + 1;
            cnt_q    <= int'(delay_i) + 1;
        end else if (cnt_q == 1) begin
            cnt_q  <= 0;
            done_o <= 1'b1; // Zero fill over, no verify
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule : dse_engine_model
`default_nettype wire

// file: sim/dse_core_tb.sv
// Self-checking bench for the security erase and freeze block
`timescale 1ns/100ps
`default_nettype none
module dse_core_tb;
    logic                clk, rst_n, strobe, lock, done, clr, frozen, enh;
    dse_pkg::dse_cmd_t   cmd;
    dse_pkg::dse_erase_t erase;
    logic [15:0]         wdata, id_data;
    logic [255:0]        mpw, upw;
    logic [47:0]         nmax, lba;
    logic [7:0]          id_word, status, error, dly;
    logic [31:0]         r;
    int                  starts, s0, clr_cnt, error_cnt, tests_run;
    int unsigned         seed = 6;
    logic [7:0]          codes [4] = '{8'hF1, 8'hF2, 8'hF6, 8'hF4};

    dse_core #(.NORMAL_TIME(16'h0012), .ENHANCED_TIME(16'h0034)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .wr_strobe_i(strobe),
        .wr_data_i(wdata), .master_pw_i(mpw), .user_pw_i(upw),
        .lock_en_i(lock), .native_max_i(nmax), .erase_o(erase),
        .erase_done_i(done), .lock_clear_o(clr), .id_word_i(id_word),
        .id_data_o(id_data), .command_status_flags_o(status),
        .command_error_flags_o(error), .frozen_o(frozen));
    dse_engine_model eng (
        .clk_i(clk), .rst_n_i(rst_n), .erase_i(erase), .delay_i(dly),
        .done_o(done), .enh_o(enh), .lba_o(lba), .starts_o(starts));

    // Clock, watchdog and lock-clear pulse count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    always @(posedge clk) if (clr === 1'b1) clr_cnt++;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic issue(input logic [7:0] code);
        cmd = '{valid: 1'b1, code: code};
        @(negedge clk);
        cmd.valid = 1'b0;
        @(negedge clk);
    endtask : issue

    // One erase attempt; ok is the model's verdict
    task automatic run(input bit prep, lk, mst, en, good, input int d);
        logic [15:0]  ctrl;
        logic [255:0] pw;
        bit           ok;
        int           c0;
        lock = lk;
        dly = d[7:0];
        r = xs();
        ctrl = {r[15:2], en, mst}; // Reserved bits random
        pw = (mst ^ !good) ? mpw : upw;
        ok = prep && (!lk || good);
        s0 = starts;
        c0 = clr_cnt;
        if (prep) issue(dse_pkg::CMD_PREPARE);
        issue(dse_pkg::CMD_ERASE);
        if (prep) begin
            for (int i = 0; i < 50 && status[3] !== 1'b1; i++) @(negedge clk);
            chk(status[dse_pkg::ST_DRQ], 1);
            for (int i = 0; i < 256; i++) begin
                r = xs();
                strobe = 1'b1;
                wdata = i == 0 ? ctrl : i <= 16 ? pw[271 - 16 * i -: 16] : r[15:0];
                @(negedge clk);
            end
            strobe = 1'b0;
            chk(status[dse_pkg::ST_DRQ], 0);
            repeat (d + 8) @(negedge clk);
        end
        chk(starts - s0, ok);
        chk(clr_cnt - c0, ok);
        chk(status[dse_pkg::ST_ERR], !ok);
        chk(error[dse_pkg::ER_ABT], !ok);
        if (ok) begin
            chk(enh, en);
            chk(lba, nmax);
            chk(status, dse_pkg::STATUS_RST);
        end
    endtask : run

    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        rst_n = 1'b0;
        cmd = '0;
        strobe = 1'b0;
        wdata = 16'h0;
        lock = 1'b1;
        id_word = 8'h0;
        dly = 8'h0;
        for (int k = 0; k < 8; k++) begin
            mpw[k * 32 +: 32] = xs();
            upw[k * 32 +: 32] = xs();
        end
        r = xs();
        nmax = {r[15:0], xs()};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(status, dse_pkg::STATUS_RST);
        chk(error, dse_pkg::ERROR_RST);
        chk(frozen, 0);
        run(0, 1, 0, 0, 1, 0);
        run(1, 1, 0, 0, 1, 0);
        run(1, 1, 1, 1, 1, 30);
        run(1, 1, 0, 1, 0, 0);
        run(1, 1, 1, 0, 0, 5);
        run(1, 0, 0, 1, 0, 3);
        for (int w = 88; w <= 91; w++) begin
            id_word = w[7:0];
            repeat (2) @(negedge clk);
            chk(id_data, w == 89 ? 16'h0012 : w == 90 ? 16'h0034 : 16'h0);
        end
        issue(dse_pkg::CMD_FREEZE);
        chk(frozen, 1);
        chk(status[dse_pkg::ST_DRQ], 0);
        s0 = starts;
        foreach (codes[k]) begin
            issue(dse_pkg::CMD_PREPARE);
            issue(codes[k]);
            chk(status[dse_pkg::ST_ERR], 1);
            chk(error[dse_pkg::ER_ABT], 1);
            chk(status[dse_pkg::ST_DRQ], 0);
        end
        chk(starts, s0);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(frozen, 1);
        chk(status, dse_pkg::STATUS_RST);
        final_report();
    end
endmodule : dse_core_tb
`default_nettype wire
